// ### include/port_group_pkg.sv
// Package for the six-pin port group: register map, field layout, encodings, timing.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none
package port_group_pkg;
  // Geometry
  localparam int PIN_COUNT = 6;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PIN_DATA = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_BUFFER_ENABLE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PULL_RESISTOR_CONTROL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PIN_INTERRUPT_FLAGS = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_PIN_INTERRUPT_CONTROL = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_DEBOUNCE_FILTER_ENABLE = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_PIN_MODE_SELECT = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_PIN_FUNCTION_SELECT = 5'h1C;

  // Field positions inside a 16-bit register
  localparam int HI_FIELD_POS = 8;
  localparam int LO_FIELD_POS = 0;
  localparam int FNC_FIELD_W = 2;

  // Reset values
  localparam logic [PIN_COUNT-1:0] RST_PIN_FIELD = 6'h00;
  localparam logic [2*PIN_COUNT-1:0] RST_FNC_FIELD = 12'h000;

  // Function selector encodings
  localparam logic [1:0] FUNC_TRIGGER = 2'h0;
  localparam logic [1:0] FUNC_UMUX = 2'h1;
  localparam logic [1:0] FUNC_ANALOG = 2'h2;
  localparam logic [1:0] FUNC_NONE = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILTER_TIME_NS = 64;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus carriers
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } avmm_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avmm_rsp_s;

  // Universal multiplexer drive towards a pin
  typedef struct packed {
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] enable;
  } umux_drive_s;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;
endpackage
`default_nettype wire

// ### logic/pin_debounce.sv
// Per-pin input filter: a level passes only after staying stable for a set count.
// Assumes inputs already registered in the system clock domain.
`default_nettype none
module pin_debounce
  import port_group_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT,
  parameter int CYCLES = FILTER_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Levels
  input wire logic [WIDTH-1:0] raw,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] filtered
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [CW-1:0] cnt_reg;
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_reg <= '0;
          filtered[i] <= 1'b0;
        end else if (raw[i] == filtered[i]) begin
          cnt_reg <= '0;
        end else if (!enable[i] || cnt_reg == LAST) begin
          cnt_reg <= '0;
          filtered[i] <= raw[i];
        end else begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end
    end
  endgenerate
endmodule // pin_debounce
`default_nettype wire

// ### logic/pin_function_mux.sv
// Per-pin routing of pin drive between general-purpose logic and peripherals.
// Assumes analog functions take the pin with no digital drive.
`default_nettype none
module pin_function_mux
  import port_group_pkg::*;
(
  // Configuration
  input wire logic [PIN_COUNT-1:0] mode,
  input wire logic [2*PIN_COUNT-1:0] fnc,
  // Sources
  input wire logic [PIN_COUNT-1:0] gpio_level,
  input wire logic [PIN_COUNT-1:0] gpio_enable,
  input wire umux_drive_s umux,
  // Pin drive
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe_n,
  output logic [PIN_COUNT-1:0] umux_sel
);
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      logic [1:0] sel;
      assign sel = fnc[FNC_FIELD_W*i +: FNC_FIELD_W];
      assign umux_sel[i] = mode[i] && sel == FUNC_UMUX;
      always_comb begin
        if (!mode[i]) begin
          pin_out[i] = gpio_level[i];
          pin_oe_n[i] = !gpio_enable[i];
        end else if (umux_sel[i]) begin
          pin_out[i] = umux.level[i];
          pin_oe_n[i] = !umux.enable[i];
        end else begin
          pin_out[i] = 1'b0;
          pin_oe_n[i] = 1'b1;
        end
      end
    end
  endgenerate
endmodule // pin_function_mux
`default_nettype wire

// ### logic/port_group.sv
// Six-pin port group: registers on Avalon-MM, pin drive, input, interrupt flags.
// Assumes pin inputs synchronous to sys_clk and a master that holds requests.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`default_nettype none

// Behaviour
// - Six independent pins 0..5; one-bit-per-pin fields six bits, selector field twelve, index order.
// - Each pin does I/O and raises a per-pin edge flag; enable gates only the interrupt.
// - Flags clear only by writing one; writing zero leaves them.
// - Mode bit 0 gives pin to I/O; 1 gives it to selected function.
// - Selector 0 connects pin 0 to converter trigger; others nothing.
// - Selector 1 routes every pin to the universal multiplexer.
// - Selector 2: pin 1 reference, pins 2..5 analog inputs; 3 nothing.
module port_group
  import port_group_pkg::*;
#(
  parameter int FILTER_LEN = FILTER_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register bus
  input wire avmm_req_s bus_req,
  output avmm_rsp_s bus_rsp,
  // Pins
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe_n,
  output logic [PIN_COUNT-1:0] pin_pull_en,
  output logic [PIN_COUNT-1:0] pin_pull_up,
  // Universal multiplexer
  input wire umux_drive_s umux_drive,
  output logic [PIN_COUNT-1:0] umux_sel,
  output logic [PIN_COUNT-1:0] umux_level,
  // Analog converter
  output logic converter_trigger_n,
  output logic converter_reference_en,
  output logic [3:0] analog_input_en,
  // Interrupt request
  output logic pin_irq
);
  bus_state_e state_reg;
  logic req;
  logic wr_fire;
  logic [DATA_W-1:0] rd_next;
  logic [DATA_W-1:0] rd_reg;
  logic [7:0] wlo;
  logic [7:0] whi;
  logic be_lo;
  logic be_hi;

  logic [PIN_COUNT-1:0] out_level_bits;
  logic [PIN_COUNT-1:0] in_level_bits;
  logic [PIN_COUNT-1:0] input_buffer_enable;
  logic [PIN_COUNT-1:0] output_buffer_enable;
  logic [PIN_COUNT-1:0] pull_direction;
  logic [PIN_COUNT-1:0] pull_enable;
  logic [PIN_COUNT-1:0] pin_irq_flag;
  logic [PIN_COUNT-1:0] irq_edge_select;
  logic [PIN_COUNT-1:0] pin_irq_enable;
  logic [PIN_COUNT-1:0] debounce_enable;
  logic [PIN_COUNT-1:0] peripheral_mode_bit;
  logic [2*PIN_COUNT-1:0] function_selector;

  logic [PIN_COUNT-1:0] filt_level;
  logic [PIN_COUNT-1:0] filt_prev_reg;
  logic [PIN_COUNT-1:0] edge_hit;
  logic [PIN_COUNT-1:0] flag_clear;
  logic [PIN_COUNT-1:0] sel_trig;
  logic [PIN_COUNT-1:0] sel_umux;
  logic [PIN_COUNT-1:0] sel_analog;
  logic [PIN_COUNT-1:0] sel_none;

  function automatic logic [PIN_COUNT-1:0] lane6(input logic [PIN_COUNT-1:0] old,
                                                 input logic [7:0] data, input logic en);
    lane6 = en ? data[PIN_COUNT-1:0] : old;
  endfunction

  // Bus handshake: one wait cycle, then answer
  assign req = bus_req.read || bus_req.write;
  assign bus_rsp.waitrequest = req && state_reg == BUS_IDLE;
  assign bus_rsp.readdata = rd_reg;
  assign wr_fire = bus_req.write && state_reg == BUS_ACK;
  assign wlo = bus_req.writedata[7:0];
  assign whi = bus_req.writedata[15:8];
  assign be_lo = bus_req.byteenable[0];
  assign be_hi = bus_req.byteenable[1];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= BUS_IDLE;
    end else begin
      case (state_reg)
        BUS_IDLE: state_reg <= req ? BUS_ACK : BUS_IDLE;
        BUS_ACK: state_reg <= BUS_IDLE;
        default: state_reg <= BUS_IDLE;
      endcase
    end
  end

  // Read mux, unmapped reads zero
  always_comb begin
    rd_next = '0;
    case (bus_req.address)
      OFS_PIN_DATA: begin
        rd_next[HI_FIELD_POS +: PIN_COUNT] = out_level_bits;
        rd_next[LO_FIELD_POS +: PIN_COUNT] = in_level_bits;
      end
      OFS_PIN_BUFFER_ENABLE: begin
        rd_next[HI_FIELD_POS +: PIN_COUNT] = input_buffer_enable;
        rd_next[LO_FIELD_POS +: PIN_COUNT] = output_buffer_enable;
      end
      OFS_PULL_RESISTOR_CONTROL: begin
        rd_next[HI_FIELD_POS +: PIN_COUNT] = pull_direction;
        rd_next[LO_FIELD_POS +: PIN_COUNT] = pull_enable;
      end
      OFS_PIN_INTERRUPT_FLAGS: rd_next[LO_FIELD_POS +: PIN_COUNT] = pin_irq_flag;
      OFS_PIN_INTERRUPT_CONTROL: begin
        rd_next[HI_FIELD_POS +: PIN_COUNT] = irq_edge_select;
        rd_next[LO_FIELD_POS +: PIN_COUNT] = pin_irq_enable;
      end
      OFS_DEBOUNCE_FILTER_ENABLE: rd_next[LO_FIELD_POS +: PIN_COUNT] = debounce_enable;
      OFS_PIN_MODE_SELECT: rd_next[LO_FIELD_POS +: PIN_COUNT] = peripheral_mode_bit;
      OFS_PIN_FUNCTION_SELECT: rd_next[LO_FIELD_POS +: 2*PIN_COUNT] = function_selector;
      default: rd_next = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg <= '0;
    end else if (bus_req.read && state_reg == BUS_IDLE) begin
      rd_reg <= rd_next;
    end
  end

  // Read/write configuration registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_level_bits <= RST_PIN_FIELD;
      input_buffer_enable <= RST_PIN_FIELD;
      output_buffer_enable <= RST_PIN_FIELD;
      pull_direction <= RST_PIN_FIELD;
      pull_enable <= RST_PIN_FIELD;
      irq_edge_select <= RST_PIN_FIELD;
      pin_irq_enable <= RST_PIN_FIELD;
      debounce_enable <= RST_PIN_FIELD;
      peripheral_mode_bit <= RST_PIN_FIELD;
      function_selector <= RST_FNC_FIELD;
    end else if (wr_fire) begin
      case (bus_req.address)
        OFS_PIN_DATA: out_level_bits <= lane6(out_level_bits, whi, be_hi);
        OFS_PIN_BUFFER_ENABLE: begin
          input_buffer_enable <= lane6(input_buffer_enable, whi, be_hi);
          output_buffer_enable <= lane6(output_buffer_enable, wlo, be_lo);
        end
        OFS_PULL_RESISTOR_CONTROL: begin
          pull_direction <= lane6(pull_direction, whi, be_hi);
          pull_enable <= lane6(pull_enable, wlo, be_lo);
        end
        OFS_PIN_INTERRUPT_CONTROL: begin
          irq_edge_select <= lane6(irq_edge_select, whi, be_hi);
          pin_irq_enable <= lane6(pin_irq_enable, wlo, be_lo);
        end
        OFS_DEBOUNCE_FILTER_ENABLE: debounce_enable <= lane6(debounce_enable, wlo, be_lo);
        OFS_PIN_MODE_SELECT: peripheral_mode_bit <= lane6(peripheral_mode_bit, wlo, be_lo);
        OFS_PIN_FUNCTION_SELECT: begin
          if (be_lo) begin
            function_selector[7:0] <= wlo;
          end
          if (be_hi) begin
            function_selector[2*PIN_COUNT-1:8] <= whi[2*PIN_COUNT-9:0];
          end
        end
        default: function_selector <= function_selector;
      endcase
    end
  end

  // Input sampling, zero while the input buffer is off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_level_bits <= RST_PIN_FIELD;
    end else begin
      in_level_bits <= pin_in & input_buffer_enable;
    end
  end

  pin_debounce #(
    .WIDTH(PIN_COUNT),
    .CYCLES(FILTER_LEN)
  ) u_debounce (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .raw(in_level_bits),
    .enable(debounce_enable),
    .filtered(filt_level)
  );

  // Edge detection: select 0 rising, 1 falling
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_prev_reg <= RST_PIN_FIELD;
    end else begin
      filt_prev_reg <= filt_level;
    end
  end

  assign edge_hit = (filt_level ^ filt_prev_reg) & (filt_level ^ irq_edge_select);

  // Sticky flags, set beats clear
  assign flag_clear = (wr_fire && bus_req.address == OFS_PIN_INTERRUPT_FLAGS && be_lo) ?
                      wlo[PIN_COUNT-1:0] : RST_PIN_FIELD;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_irq_flag <= RST_PIN_FIELD;
    end else begin
      pin_irq_flag <= (pin_irq_flag & ~flag_clear) | edge_hit;
    end
  end

  assign pin_irq = |(pin_irq_flag & pin_irq_enable);

  // Pin drive routing
  pin_function_mux u_mux (
    .mode(peripheral_mode_bit),
    .fnc(function_selector),
    .gpio_level(out_level_bits),
    .gpio_enable(output_buffer_enable),
    .umux(umux_drive),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .umux_sel(umux_sel)
  );

  assign pin_pull_en = pull_enable;
  assign pin_pull_up = pull_direction;
  assign umux_level = pin_in;

  // Converter connections
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_trigger_n <= 1'b1;
      converter_reference_en <= 1'b0;
      analog_input_en <= 4'h0;
    end else begin
      converter_trigger_n <= (peripheral_mode_bit[0] && function_selector[1:0] == FUNC_TRIGGER) ?
                             pin_in[0] : 1'b1;
      converter_reference_en <= peripheral_mode_bit[1] && function_selector[3:2] == FUNC_ANALOG;
      for (int k = 0; k < 4; k++) begin
        analog_input_en[k] <= peripheral_mode_bit[k+2] &&
                              function_selector[2*(k+2) +: 2] == FUNC_ANALOG;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Per-pin selector decode for the checks
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_dec
      logic [FNC_FIELD_W-1:0] code;
      assign code = function_selector[FNC_FIELD_W*g +: FNC_FIELD_W];
      assign sel_trig[g] = peripheral_mode_bit[g] && code == FUNC_TRIGGER;
      assign sel_umux[g] = peripheral_mode_bit[g] && code == FUNC_UMUX;
      assign sel_analog[g] = peripheral_mode_bit[g] && code == FUNC_ANALOG;
      assign sel_none[g] = peripheral_mode_bit[g] && code == FUNC_NONE;
    end
  endgenerate

  a_bus_one_wait: assert property (bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
    else $error("waitrequest held beyond one cycle");
  a_bus_idle_nowait: assert property (!req |-> !bus_rsp.waitrequest)
    else $error("waitrequest without request");
  a_read_hold: assert property (!(bus_req.read && state_reg == BUS_IDLE) |=> $stable(bus_rsp.readdata))
    else $error("read data moved without a read");
  a_read_width: assert property ((bus_req.read && state_reg == BUS_ACK) |->
                                 bus_rsp.readdata[DATA_W-1:14] == '0 &&
                                 (bus_req.address == OFS_PIN_FUNCTION_SELECT ?
                                  bus_rsp.readdata[13:12] == 2'h0 : bus_rsp.readdata[7:6] == 2'h0))
    else $error("read data has bits outside six-pin fields");
  a_lane_hi_keep: assert property ((wr_fire && bus_req.address == OFS_PIN_FUNCTION_SELECT && !be_hi) |=>
                                   $stable(function_selector[11:8]))
    else $error("high lane written without byte enable");
  a_lane_lo_keep: assert property ((wr_fire && bus_req.address == OFS_PIN_MODE_SELECT && !be_lo) |=>
                                   $stable(peripheral_mode_bit))
    else $error("low lane written without byte enable");

  a_irq_raise: assert property ((|(edge_hit & pin_irq_enable)) |=> pin_irq)
    else $error("enabled edge did not raise the interrupt");
  a_flag_w1c: assert property ((|flag_clear) && !(|edge_hit) |=>
                               pin_irq_flag == ($past(pin_irq_flag) & ~$past(flag_clear)))
    else $error("flag write-one-to-clear wrong");
  a_flag_zero_keep: assert property ((wr_fire && bus_req.address == OFS_PIN_INTERRUPT_FLAGS &&
                                      wlo[PIN_COUNT-1:0] == '0) |=> pin_irq_flag == ($past(pin_irq_flag) | $past(edge_hit)))
    else $error("writing zero changed a flag");
  a_gpio_drive: assert property (((pin_out ^ out_level_bits) & ~peripheral_mode_bit & ~pin_oe_n) == '0 &&
                                 (pin_oe_n & ~peripheral_mode_bit & output_buffer_enable) == '0)
    else $error("general-purpose pin drive wrong");
  a_trigger_route: assert property ((peripheral_mode_bit[0] && function_selector[1:0] == FUNC_TRIGGER) |=>
                                    converter_trigger_n == $past(pin_in[0]))
    else $error("trigger not following pin 0");
  a_umux_route: assert property ((peripheral_mode_bit[5] && function_selector[11:10] == FUNC_UMUX) |->
                                 umux_sel[5] && pin_oe_n[5] == !umux_drive.enable[5])
    else $error("pin 5 not routed to multiplexer");
  a_analog_route: assert property ((peripheral_mode_bit[2] && function_selector[5:4] == FUNC_ANALOG) |=>
                                   analog_input_en[0])
    else $error("pin 2 not routed to analog input 0");
  a_none_func: assert property ((peripheral_mode_bit[3] && function_selector[7:6] == FUNC_NONE) |->
                                pin_oe_n[3] && !umux_sel[3])
    else $error("selector 3 drives pin 3");
  a_input_gate: assert property ((in_level_bits & ~$past(input_buffer_enable)) == '0)
    else $error("input bit set with input buffer off");
  a_input_sample: assert property (in_level_bits == ($past(pin_in) & $past(input_buffer_enable)))
    else $error("input bit not following pin");

  a_flag_set_wins: assert property ((|edge_hit) |=> (pin_irq_flag & $past(edge_hit)) == $past(edge_hit))
    else $error("edge lost against a clear");
  a_flag_no_drop: assert property (($past(pin_irq_flag) & ~pin_irq_flag & ~$past(flag_clear)) == '0)
    else $error("flag dropped without a one written");

  a_trigger_idle: assert property (!sel_trig[0] |=> converter_trigger_n)
    else $error("trigger active without selection");
  a_unrouted_float: assert property (((sel_trig | sel_analog | sel_none) & ~pin_oe_n) == '0)
    else $error("unrouted pin driven");
  a_umux_all: assert property (umux_sel == sel_umux)
    else $error("multiplexer hand-over wrong");
  a_analog_all: assert property (analog_input_en == $past(sel_analog[5:2]) &&
                                 converter_reference_en == $past(sel_analog[1]))
    else $error("analog routing wrong");

  c_flag_set: cover property (|edge_hit ##1 pin_irq);
  c_flag_clear: cover property ((|(flag_clear & pin_irq_flag)) ##1 !pin_irq);
  c_umux_use: cover property (|umux_sel);
  c_trigger_use: cover property (sel_trig[0] ##1 !converter_trigger_n);
  c_analog_use: cover property (|analog_input_en);
endmodule // port_group
`default_nettype wire

// ### sim/pin_world.sv
// Pin-side model: resolves each pad from device drive, external drive and pulls.
// Assumes one sys_clk domain; pin_in returned combinationally to the port group.
`default_nettype none
module pin_world
  import port_group_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Device drive
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe_n,
  input wire logic [PIN_COUNT-1:0] pin_pull_en,
  input wire logic [PIN_COUNT-1:0] pin_pull_up,
  // External driver
  input wire logic [PIN_COUNT-1:0] ext_en,
  input wire logic [PIN_COUNT-1:0] ext_level,
  // Pad level
  output logic [PIN_COUNT-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [PIN_COUNT-1:0] last_reg = 6'h00;

  // Device first, then outside driver, then pull, else floating toggle
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (pin_oe_n[i] == 1'b0) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_level[i];
      end else if (pin_pull_en[i]) begin
        pin_in[i] = pin_pull_up[i];
      end else begin
        pin_in[i] = ~last_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    last_reg <= pin_in;
  end
endmodule // pin_world
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the six-pin port group over Avalon-MM.
// Assumes pin_world as pad model and a short filter length for speed.
`default_nettype none
module tb;
  import port_group_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  avmm_req_s bus_req = '0;
  avmm_rsp_s bus_rsp;
  umux_drive_s umux_drive = '0;
  logic [5:0] pin_in, pin_out, pin_oe_n, pin_pull_en, pin_pull_up, umux_sel, umux_level;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] ext_level = 6'h00;
  logic converter_trigger_n, converter_reference_en, pin_irq;
  logic [3:0] analog_input_en;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #4 sys_clk = ~sys_clk;

  port_group #(.FILTER_LEN(2)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_en(pin_pull_en), .pin_pull_up(pin_pull_up), .umux_drive(umux_drive),
    .umux_sel(umux_sel), .umux_level(umux_level), .converter_trigger_n(converter_trigger_n),
    .converter_reference_en(converter_reference_en), .analog_input_en(analog_input_en),
    .pin_irq(pin_irq));

  pin_world i_pins (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_en(pin_pull_en), .pin_pull_up(pin_pull_up), .ext_en(ext_en),
    .ext_level(ext_level), .pin_in(pin_in));

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [4:0] adr, input logic [31:0] wd,
                          input logic [3:0] be, output logic [31:0] rd);
    int n = 0;
    @(posedge sys_clk);
    bus_req.read <= ~wr;
    bus_req.write <= wr;
    bus_req.address <= adr;
    bus_req.writedata <= wd;
    bus_req.byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
    rd = bus_rsp.readdata;
    if (n >= 50) begin
      num_errors++;
    end
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask

  // Write, then one edge so that its effect has settled
  task automatic wr_lane(input logic [4:0] adr, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus_xfer(1'b1, adr, wd, be, d);
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] wd);
    wr_lane(adr, wd, 4'hF);
  endtask

  task automatic rd_chk(input logic [4:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus_xfer(1'b0, adr, 32'h0000_0000, 4'hF, d);
    chk(what, exp, d);
  endtask

  task automatic wait_irq;
    int n = 0;
    while (pin_irq !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk("pin_irq raised", 32'h0000_0001, 32'(pin_irq));
  endtask

  task automatic test_reset;
    chk("pin_oe_n", 32'h0000_003F, 32'(pin_oe_n));
    chk("trigger_n", 32'h0000_0001, 32'(converter_trigger_n));
    wr(5'h02, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      rd_chk(5'(4 * i), 32'h0000_0000, "reset value");
    end
    rd_chk(5'h02, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask

  task automatic test_gpio;
    wr(OFS_PIN_BUFFER_ENABLE, 32'h0000_3F3F);
    wr(OFS_PIN_DATA, 32'hFFFF_EA15);
    rd_chk(OFS_PIN_BUFFER_ENABLE, 32'h0000_3F3F, "buffer enable");
    chk("pin_out", 32'h0000_002A, 32'(pin_out));
    chk("pin_oe_n", 32'h0000_0000, 32'(pin_oe_n));
    rd_chk(OFS_PIN_DATA, 32'h0000_2A2A, "data loopback");
    wr(OFS_PIN_BUFFER_ENABLE, 32'h0000_003F);
    repeat (4) @(posedge sys_clk);
    rd_chk(OFS_PIN_DATA, 32'h0000_2A00, "input off");
    $display("test gpio done");
  endtask

  task automatic test_pull;
    wr(OFS_PULL_RESISTOR_CONTROL, 32'h0000_0F3F);
    wr(OFS_PIN_BUFFER_ENABLE, 32'h0000_3F00);
    chk("pull_en", 32'h0000_003F, 32'(pin_pull_en));
    chk("pull_up", 32'h0000_000F, 32'(pin_pull_up));
    repeat (4) @(posedge sys_clk);
    rd_chk(OFS_PIN_DATA, 32'h0000_2A0F, "pulled input");
    $display("test pull done");
  endtask

  task automatic test_irq;
    wr(OFS_PULL_RESISTOR_CONTROL, 32'h0000_003F);
    wr(OFS_PIN_INTERRUPT_CONTROL, 32'h0000_003F);
    repeat (4) @(posedge sys_clk);
    wr(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_003F);
    chk("pin_irq idle", 32'h0000_0000, 32'(pin_irq));
    ext_en <= 6'h04;
    ext_level <= 6'h04;
    wait_irq();
    rd_chk(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_0004, "rise flag");
    wr(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_003B);
    rd_chk(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_0004, "zero write");
    wr(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_0004);
    rd_chk(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_0000, "one write");
    chk("pin_irq cleared", 32'h0000_0000, 32'(pin_irq));
    wr(OFS_PIN_INTERRUPT_CONTROL, 32'h0000_3F3F);
    ext_level <= 6'h00;
    wait_irq();
    wr(OFS_PIN_INTERRUPT_CONTROL, 32'h0000_3F00);
    chk("pin_irq masked", 32'h0000_0000, 32'(pin_irq));
    rd_chk(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_0004, "fall flag");
    wr(OFS_DEBOUNCE_FILTER_ENABLE, 32'h0000_003F);
    rd_chk(OFS_DEBOUNCE_FILTER_ENABLE, 32'h0000_003F, "filter enable");
    wr(OFS_PIN_INTERRUPT_FLAGS, 32'h0000_003F);
    wr(OFS_PIN_INTERRUPT_CONTROL, 32'h0000_0004);
    ext_level <= 6'h04;
    wait_irq();
    $display("test irq done");
  endtask

  task automatic test_func;
    logic [1:0] s;
    ext_en <= 6'h01;
    ext_level <= 6'h00;
    umux_drive.level <= 6'h15;
    umux_drive.enable <= 6'h3C;
    wr(OFS_PIN_MODE_SELECT, 32'h0000_003F);
    for (int k = 0; k < 4; k++) begin
      s = 2'(k);
      wr(OFS_PIN_FUNCTION_SELECT, {20'h0_0000, {6{s}}});
      repeat (3) @(posedge sys_clk);
      chk("umux_sel", (s == FUNC_UMUX) ? 32'h0000_003F : 32'h0000_0000, 32'(umux_sel));
      chk("pin_oe_n", (s == FUNC_UMUX) ? 32'h0000_0003 : 32'h0000_003F, 32'(pin_oe_n));
      chk("umux level", (s == FUNC_UMUX) ? 32'h0000_0014 : 32'h0000_0000, 32'(umux_level & 6'h3E));
      chk("trigger_n", (s == FUNC_TRIGGER) ? 32'h0000_0000 : 32'h0000_0001, 32'(converter_trigger_n));
      chk("reference", (s == FUNC_ANALOG) ? 32'h0000_0001 : 32'h0000_0000, 32'(converter_reference_en));
      chk("analog in", (s == FUNC_ANALOG) ? 32'h0000_000F : 32'h0000_0000, 32'(analog_input_en));
    end
    wr(OFS_PIN_MODE_SELECT, 32'h0000_0000);
    wr(OFS_PIN_FUNCTION_SELECT, 32'h0000_0555);
    chk("gpio mode sel", 32'h0000_0000, 32'(umux_sel));
    wr_lane(OFS_PIN_FUNCTION_SELECT, 32'h0000_0FFF, 4'h2);
    rd_chk(OFS_PIN_FUNCTION_SELECT, 32'h0000_0F55, "high lane");
    wr_lane(OFS_PIN_FUNCTION_SELECT, 32'h0000_0F00, 4'h1);
    rd_chk(OFS_PIN_FUNCTION_SELECT, 32'h0000_0F00, "low lane");
    $display("test func done");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    test_reset();
    test_gpio();
    test_pull();
    test_irq();
    test_func();
    stop_test();
  end
endmodule // tb
`default_nettype wire
